// >>> rtl/csp_serial_port.sv
// Notes on behaviour
// - The transmit fifo always has 16 stages, whatever is written to tx_watermark_field.
// - The receive fifo always has 16 stages, whatever is written to rx_watermark_field.
// - A request to refill the transmit fifo shows as tx_refill_request in port_status_reg.
// - A request to drain the receive fifo shows as rx_drain_request in port_status_reg.
// - Writing 1 to tx_reset_bit or rx_reset_bit resets that direction's fifo and shifter.
// - There is no spi mode, no spi control register and no spi pin function.
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module csp_serial_port
  import csp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [CSP_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mclk_pin,
  input wire logic sd_in_pin,
  output logic sck_out,
  output logic fs_out,
  output logic sd_out,
  output logic irq
);

  logic pready_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic tx_en_reg;
  logic rx_en_reg;
  logic tx_rst_reg;
  logic rx_rst_reg;
  csp_clk_cfg_type clk_cfg_reg;
  logic [15:0] fifoctl_reg;
  logic [CSP_EV_W-1:0] status_reg;
  logic [CSP_EV_W-1:0] mask_reg;
  logic [CSP_EV_W-1:0] ev_set;
  logic irq_reg;
  logic mclk_s1, mclk_s2, mclk_s3;
  logic sdin_s1, sdin_s2;
  logic [4:0] psc_cnt_reg;
  logic [7:0] div_cnt_reg;
  logic [7:0] div_lim;
  logic src_tick, psc_tick, half_en;
  logic [CSP_DATA_W-1:0] tx_mem [CSP_DEPTH];
  logic [CSP_DATA_W-1:0] rx_mem [CSP_DEPTH];
  logic [CSP_PTR_W-1:0] tx_wp_reg, tx_rp_reg, rx_wp_reg, rx_rp_reg;
  logic [CSP_CNT_W-1:0] tx_cnt_reg, rx_cnt_reg;
  logic tx_push, tx_pop, rx_push, rx_pop;
  logic tx_full, tx_empty, rx_full, rx_empty;
  csp_state_type state_reg;
  logic [3:0] bit_cnt_reg;
  logic [CSP_DATA_W-1:0] tx_sh_reg, rx_sh_reg;
  logic sck_reg, fs_reg, sd_reg;
  logic acc_first, acc_done, wr_done, rd_done;
  logic [31:0] rd_val;
  logic addr_ok;
  logic word_end;

  // apb phases: answer comes one cycle into the access phase
  assign acc_first = psel & penable & ~pready_reg;
  assign acc_done = psel & penable & pready_reg;
  assign wr_done = acc_done & pwrite;
  assign rd_done = acc_done & ~pwrite;

  // register read view; unmapped addresses answer with an error
  always_comb begin
    rd_val = 32'h0000_0000;
    addr_ok = 1'b1;
    case (paddr)
      CSP_OFF_CTRL: begin
        rd_val[CSP_CTRL_TXEN] = tx_en_reg;
        rd_val[CSP_CTRL_RXEN] = rx_en_reg;
        rd_val[CSP_CTRL_TX_RESET_BIT] = tx_rst_reg;
        rd_val[CSP_CTRL_RX_RESET_BIT] = rx_rst_reg;
      end
      CSP_OFF_CLKSEL: begin
        rd_val[CSP_CLK_MSS] = clk_cfg_reg.mss;
        rd_val[CSP_CLK_PSC_LSB +: 5] = clk_cfg_reg.psc;
        rd_val[CSP_CLK_DIV_LSB +: 3] = clk_cfg_reg.div;
      end
      CSP_OFF_FIFOCTL: rd_val[15:0] = fifoctl_reg;
      CSP_OFF_STATUS: rd_val[CSP_EV_W-1:0] = status_reg;
      CSP_OFF_MASK: rd_val[CSP_EV_W-1:0] = mask_reg;
      CSP_OFF_TXDATA: rd_val = 32'h0000_0000;
      CSP_OFF_RXDATA: rd_val[CSP_DATA_W-1:0] = rx_empty ? 16'h0000 : rx_mem[rx_rp_reg];
      CSP_OFF_LEVEL: begin
        rd_val[CSP_LVL_RX_LSB +: CSP_CNT_W] = rx_cnt_reg;
        rd_val[CSP_CNT_W-1:0] = tx_cnt_reg;
      end
      default: addr_ok = 1'b0;
    endcase
  end

  // apb handshake and read data capture
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= acc_first;
      if (acc_first) begin
        prdata_reg <= pwrite ? 32'h0000_0000 : rd_val;
        pslverr_reg <= ~addr_ok;
      end else begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  // control register; reset bits are one-cycle pulses
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tx_en_reg <= 1'b0;
      rx_en_reg <= 1'b0;
      tx_rst_reg <= 1'b0;
      rx_rst_reg <= 1'b0;
    end else if (wr_done && paddr == CSP_OFF_CTRL) begin
      tx_en_reg <= pwdata[CSP_CTRL_TXEN];
      rx_en_reg <= pwdata[CSP_CTRL_RXEN];
      tx_rst_reg <= pwdata[CSP_CTRL_TX_RESET_BIT];
      rx_rst_reg <= pwdata[CSP_CTRL_RX_RESET_BIT];
    end else begin
      tx_rst_reg <= 1'b0;
      rx_rst_reg <= 1'b0;
    end
  end

  // clock select and fifo control; watermarks are stored for readback only
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      clk_cfg_reg <= csp_clk_cfg_type'(CSP_CLK_RESET[8:0]);
      fifoctl_reg <= CSP_FIFOCTL_RESET;
    end else if (wr_done) begin
      if (paddr == CSP_OFF_CLKSEL) begin
        // software prepares the clock here before a reset
        clk_cfg_reg.mss <= pwdata[CSP_CLK_MSS];
        clk_cfg_reg.psc <= pwdata[CSP_CLK_PSC_LSB +: 5];
        clk_cfg_reg.div <= pwdata[CSP_CLK_DIV_LSB +: 3];
      end
      if (paddr == CSP_OFF_FIFOCTL) begin
        fifoctl_reg <= pwdata[15:0] & CSP_FIFOCTL_MASK;
      end
    end
  end

  // pin synchronisers; the second stage feeds logic, and the third stage feeds the mclk edge detect
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mclk_s1 <= 1'b0;
      mclk_s2 <= 1'b0;
      mclk_s3 <= 1'b0;
      sdin_s1 <= 1'b0;
      sdin_s2 <= 1'b0;
    end else begin
      mclk_s1 <= mclk_pin;
      mclk_s2 <= mclk_s1;
      mclk_s3 <= mclk_s2;
      sdin_s1 <= sd_in_pin;
      sdin_s2 <= sdin_s1;
    end
  end

  // baud generator: source, prescaler (psc+1), divider (2^(div+1), or 1 for 111)
  assign src_tick = clk_cfg_reg.mss | (mclk_s2 & ~mclk_s3);
  assign psc_tick = src_tick && (psc_cnt_reg == clk_cfg_reg.psc);
  assign div_lim = (8'h02 << clk_cfg_reg.div) - 8'h01;
  assign half_en = psc_tick && (clk_cfg_reg.div == CSP_DIV_ONE || div_cnt_reg == div_lim);

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      psc_cnt_reg <= 5'h00;
      div_cnt_reg <= 8'h00;
    end else begin
      if (psc_tick) begin
        psc_cnt_reg <= 5'h00;
      end else if (src_tick) begin
        psc_cnt_reg <= psc_cnt_reg + 5'h01;
      end
      if (half_en) begin
        div_cnt_reg <= 8'h00;
      end else if (psc_tick) begin
        div_cnt_reg <= div_cnt_reg + 8'h01;
      end
    end
  end

  // fifo flags, fixed at full depth
  assign tx_full = tx_cnt_reg == CSP_FULL_CNT;
  assign tx_empty = tx_cnt_reg == '0;
  assign rx_full = rx_cnt_reg == CSP_FULL_CNT;
  assign rx_empty = rx_cnt_reg == '0;
  assign tx_push = wr_done && paddr == CSP_OFF_TXDATA && !tx_full;
  assign tx_pop = state_reg == CSP_LOAD && tx_en_reg && !tx_empty;
  assign word_end = state_reg == CSP_SHIFT && half_en && sck_reg && bit_cnt_reg == CSP_LAST_BIT;
  assign rx_push = word_end && rx_en_reg && !rx_full;
  assign rx_pop = rd_done && paddr == CSP_OFF_RXDATA && !rx_empty;

  // fifo storage, no reset needed on the data words
  always_ff @(posedge clk_sys) begin
    if (tx_push) begin
      tx_mem[tx_wp_reg] <= pwdata[CSP_DATA_W-1:0];
    end
    if (rx_push) begin
      rx_mem[rx_wp_reg] <= rx_sh_reg;
    end
  end

  // transmit fifo pointers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tx_wp_reg <= '0;
      tx_rp_reg <= '0;
      tx_cnt_reg <= '0;
    end else if (tx_rst_reg) begin
      tx_wp_reg <= '0;
      tx_rp_reg <= '0;
      tx_cnt_reg <= '0;
    end else begin
      tx_wp_reg <= tx_wp_reg + CSP_PTR_W'(tx_push);
      tx_rp_reg <= tx_rp_reg + CSP_PTR_W'(tx_pop);
      tx_cnt_reg <= tx_cnt_reg + CSP_CNT_W'(tx_push) - CSP_CNT_W'(tx_pop);
    end
  end

  // receive fifo pointers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rx_wp_reg <= '0;
      rx_rp_reg <= '0;
      rx_cnt_reg <= '0;
    end else if (rx_rst_reg) begin
      rx_wp_reg <= '0;
      rx_rp_reg <= '0;
      rx_cnt_reg <= '0;
    end else begin
      rx_wp_reg <= rx_wp_reg + CSP_PTR_W'(rx_push);
      rx_rp_reg <= rx_rp_reg + CSP_PTR_W'(rx_pop);
      rx_cnt_reg <= rx_cnt_reg + CSP_CNT_W'(rx_push) - CSP_CNT_W'(rx_pop);
    end
  end

  // serial engine: master mode only, 16-bit words msb first, frame sync on bit 0
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= CSP_IDLE;
      bit_cnt_reg <= 4'h0;
      tx_sh_reg <= '0;
      rx_sh_reg <= '0;
      sck_reg <= 1'b0;
      fs_reg <= 1'b0;
      sd_reg <= 1'b0;
    end else begin
      case (state_reg)
        CSP_IDLE: begin
          sck_reg <= 1'b0;
          fs_reg <= 1'b0;
          if (tx_en_reg || rx_en_reg) begin
            state_reg <= CSP_LOAD;
          end
        end
        CSP_LOAD: begin
          // an empty fifo sends zeros; software avoids it by prefilling
          tx_sh_reg <= tx_pop ? tx_mem[tx_rp_reg] : '0;
          sd_reg <= tx_pop ? tx_mem[tx_rp_reg][CSP_DATA_W-1] : 1'b0;
          fs_reg <= 1'b1;
          bit_cnt_reg <= 4'h0;
          state_reg <= CSP_SHIFT;
        end
        CSP_SHIFT: begin
          if (half_en && !sck_reg) begin
            sck_reg <= 1'b1;
            rx_sh_reg <= {rx_sh_reg[CSP_DATA_W-2:0], sdin_s2};
          end else if (half_en) begin
            sck_reg <= 1'b0;
            if (bit_cnt_reg == CSP_LAST_BIT) begin
              state_reg <= (tx_en_reg || rx_en_reg) ? CSP_LOAD : CSP_IDLE;
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              tx_sh_reg <= {tx_sh_reg[CSP_DATA_W-2:0], 1'b0};
              sd_reg <= tx_sh_reg[CSP_DATA_W-2];
              fs_reg <= 1'b0;
            end
          end
        end
        default: state_reg <= CSP_IDLE;
      endcase
      // direction reset also clears its shifter
      if (tx_rst_reg) begin
        tx_sh_reg <= '0;
        sd_reg <= 1'b0;
      end
      if (rx_rst_reg) begin
        rx_sh_reg <= '0;
      end
    end
  end

  // event sources; fifo requests are judged against the full 16 stages
  always_comb begin
    ev_set = '0;
    // refill request when transmit fifo runs dry
    ev_set[CSP_EV_TXREQ] = tx_empty;
    // drain request when receive fifo is full
    ev_set[CSP_EV_RXREQ] = rx_full;
    ev_set[CSP_EV_TXUNDER] = state_reg == CSP_LOAD && tx_en_reg && tx_empty;
    ev_set[CSP_EV_RXOVER] = word_end && rx_en_reg && rx_full;
  end

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      status_reg <= '0;
      mask_reg <= '0;
    end else begin
      if (wr_done && paddr == CSP_OFF_STATUS) begin
        status_reg <= (status_reg & ~pwdata[CSP_EV_W-1:0]) | ev_set;
      end else begin
        status_reg <= status_reg | ev_set;
      end
      if (wr_done && paddr == CSP_OFF_MASK) begin
        mask_reg <= pwdata[CSP_EV_W-1:0];
      end
    end
  end

  // level interrupt from registered status and mask
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_reg & mask_reg);
    end
  end

  // every output straight from a flip-flop
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign sck_out = sck_reg;
  assign fs_out = fs_reg;
  assign sd_out = sd_reg;
  assign irq = irq_reg;

endmodule

// >>> rtl/csp_pkg.sv
package csp_pkg;
  // data path and fifo shape, fixed
  localparam int unsigned CSP_DATA_W = 16;
  localparam int unsigned CSP_DEPTH = 16;
  localparam int unsigned CSP_PTR_W = 4;
  localparam int unsigned CSP_CNT_W = 5;
  localparam logic [4:0] CSP_FULL_CNT = 5'h10;
  localparam logic [3:0] CSP_LAST_BIT = 4'hf;
  // apb register map, byte addresses
  localparam int unsigned CSP_ADDR_W = 8;
  localparam logic [7:0] CSP_OFF_CTRL = 8'h00;
  localparam logic [7:0] CSP_OFF_CLKSEL = 8'h04;
  localparam logic [7:0] CSP_OFF_FIFOCTL = 8'h08;
  localparam logic [7:0] CSP_OFF_STATUS = 8'h0c;
  localparam logic [7:0] CSP_OFF_MASK = 8'h10;
  localparam logic [7:0] CSP_OFF_TXDATA = 8'h14;
  localparam logic [7:0] CSP_OFF_RXDATA = 8'h18;
  localparam logic [7:0] CSP_OFF_LEVEL = 8'h1c;
  // port_control_reg fields
  localparam int unsigned CSP_CTRL_RX_RESET_BIT = 0;
  localparam int unsigned CSP_CTRL_TX_RESET_BIT = 1;
  localparam int unsigned CSP_CTRL_RXEN = 8;
  localparam int unsigned CSP_CTRL_TXEN = 9;
  // clock_select_reg fields
  localparam int unsigned CSP_CLK_MSS = 15;
  localparam int unsigned CSP_CLK_PSC_LSB = 8;
  localparam int unsigned CSP_CLK_DIV_LSB = 0;
  localparam logic [2:0] CSP_DIV_ONE = 3'h7;
  localparam logic [15:0] CSP_CLK_RESET = 16'h0000;
  // fifo_control: only the watermark fields are stored
  localparam logic [15:0] CSP_FIFOCTL_MASK = 16'he0e0;
  localparam logic [15:0] CSP_FIFOCTL_RESET = 16'h0000;
  // port_status_reg event bits
  localparam int unsigned CSP_EV_W = 4;
  localparam int unsigned CSP_EV_TXREQ = 0;
  localparam int unsigned CSP_EV_RXREQ = 1;
  localparam int unsigned CSP_EV_TXUNDER = 2;
  localparam int unsigned CSP_EV_RXOVER = 3;
  // level register: rx count at this lsb, tx count at 0
  localparam int unsigned CSP_LVL_RX_LSB = 8;

  typedef struct packed {
    logic mss;
    logic [4:0] psc;
    logic [2:0] div;
  } csp_clk_cfg_type;

  typedef enum logic [2:0] {
    CSP_IDLE = 3'b001,
    CSP_LOAD = 3'b010,
    CSP_SHIFT = 3'b100
  } csp_state_type;
endpackage

// >>> bench/csp_serial_port_assertions.sv
`timescale 1ns/1ps
module csp_serial_port_assertions
  import csp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [CSP_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mclk_pin,
  input wire logic sd_in_pin,
  input wire logic sck_out,
  input wire logic fs_out,
  input wire logic sd_out,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // apb slave timing: exactly one wait state, one-cycle answer
  a_ready_wait: assert property (psel && !penable |-> ##2 pready) else $error("pready not two cycles after setup");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held too long");
  a_ready_cause: assert property (pready |-> $past(psel) && $past(penable)) else $error("pready without access");
  // unmapped places answer with an error, so no hidden mode register exists
  a_err_unmapped: assert property (pready && paddr > 8'h1c |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (pready && paddr <= 8'h1c && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");
  // frame sync marks the first bit only, data moves only while bit clock is low
  a_fs_ends: assert property ($fell(sck_out) |-> !fs_out) else $error("frame sync beyond first bit");
  a_fs_start: assert property ($rose(fs_out) |-> !sck_out) else $error("frame sync with clock high");
  a_sd_hold: assert property (sck_out |-> $stable(sd_out)) else $error("data moved while clock high");
endmodule

// >>> bench/csp_codec_model.sv
`timescale 1ns/1ps
// far-end codec: sends one fixed word per frame, changes data on the falling bit clock
module csp_codec_model #(
  parameter logic [15:0] PAT = 16'ha5c3
) (
  input wire logic sck_out,
  input wire logic fs_out,
  output logic mclk_pin,
  output logic sd_in_pin
);
  int idx;
  // master clock runs free, phase unrelated to the system clock
  initial begin
    mclk_pin = 1'b0;
    sd_in_pin = 1'b0;
    idx = -1;
    #3;
    forever #80 mclk_pin = ~mclk_pin;
  end
  // frame start puts the msb out
  always @(posedge fs_out) begin
    sd_in_pin = PAT[15];
    idx = 14;
  end
  // once the word is out the line is let go, shown as a toggling level
  always @(negedge sck_out) begin
    if (idx >= 0) begin
      sd_in_pin = PAT[idx[3:0]];
      idx = idx - 1;
    end else begin
      sd_in_pin = ~sd_in_pin;
    end
  end
endmodule

// >>> bench/csp_serial_port_tb.sv
`timescale 1ns/1ps
module csp_serial_port_tb;
  import csp_pkg::*;
  logic clk_sys, sys_rst, psel, penable, pwrite, mclk_pin, sd_in_pin;
  logic sck_out, fs_out, sd_out, irq, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [32:0] expq[$];
  int n_errors, compares;
  csp_serial_port u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mclk_pin(mclk_pin), .sd_in_pin(sd_in_pin), .sck_out(sck_out),
    .fs_out(fs_out), .sd_out(sd_out), .irq(irq));
  csp_codec_model u_codec (.sck_out(sck_out), .fs_out(fs_out), .mclk_pin(mclk_pin), .sd_in_pin(sd_in_pin));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic report_and_stop();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // apb master; reads note {error, data} expected, the watcher compares
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [31:0] e);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    if (!w) expq.push_back({a > 8'h1c, e});
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      n_errors++;
      report_and_stop();
    end
  endtask
  // bounded wait for the interrupt line to reach a level
  task automatic wait_irq(input logic v);
    int n;
    n = 0;
    while (irq !== v && n < 30000) begin
      @(posedge clk_sys);
      n++;
    end
    check({32'h0, irq}, {32'h0, v});
    if (n >= 30000) begin
      n_errors++;
      report_and_stop();
    end
  endtask
  // watcher: oldest note against each read answer
  always @(posedge clk_sys) begin
    if (pready === 1'b1 && pwrite === 1'b0 && expq.size() > 0) check({pslverr, prdata}, expq.pop_front());
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    sys_rst = 1'b1;
    void'($urandom(62));
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    apb(CSP_OFF_FIFOCTL, 1'b0, 32'h0, 32'h0);
    apb(CSP_OFF_STATUS, 1'b0, 32'h0, 32'h1);
    r = $urandom;
    apb(CSP_OFF_FIFOCTL, 1'b1, r, 32'h0);
    apb(CSP_OFF_FIFOCTL, 1'b0, 32'h0, {16'h0, r[15:0] & CSP_FIFOCTL_MASK});
    // seventeen words: the last must be dropped whatever the watermark says
    for (int i = 0; i < 17; i++) apb(CSP_OFF_TXDATA, 1'b1, $urandom, 32'h0);
    apb(CSP_OFF_LEVEL, 1'b0, 32'h0, 32'h10);
    apb(CSP_OFF_STATUS, 1'b1, 32'hf, 32'h0);
    apb(CSP_OFF_STATUS, 1'b0, 32'h0, 32'h0);
    apb(8'h20, 1'b0, 32'h0, 32'h0);
    // clock prepared before the direction reset
    apb(CSP_OFF_CLKSEL, 1'b1, 32'h8007, 32'h0);
    apb(CSP_OFF_CTRL, 1'b1, 32'h2, 32'h0);
    apb(CSP_OFF_CTRL, 1'b0, 32'h0, 32'h0);
    apb(CSP_OFF_LEVEL, 1'b0, 32'h0, 32'h0);
    apb(CSP_OFF_STATUS, 1'b0, 32'h0, 32'h1);
    apb(CSP_OFF_MASK, 1'b1, 32'h1, 32'h0);
    wait_irq(1'b1);
    // link on the external clock, underflow interrupt on
    apb(CSP_OFF_CLKSEL, 1'b1, 32'h7, 32'h0);
    apb(CSP_OFF_MASK, 1'b1, 32'h4, 32'h0);
    wait_irq(1'b0);
    // sixth word written before transmit is enabled
    for (int i = 0; i < 6; i++) apb(CSP_OFF_TXDATA, 1'b1, $urandom, 32'h0);
    apb(CSP_OFF_CTRL, 1'b1, 32'h300, 32'h0);
    wait_irq(1'b1);
    apb(CSP_OFF_MASK, 1'b1, 32'h2, 32'h0);
    wait_irq(1'b0);
    wait_irq(1'b1);
    apb(CSP_OFF_CTRL, 1'b1, 32'h0, 32'h0);
    apb(CSP_OFF_STATUS, 1'b0, 32'h0, 32'h7);
    apb(CSP_OFF_RXDATA, 1'b0, 32'h0, 32'ha5c3);
    apb(CSP_OFF_STATUS, 1'b1, 32'hf, 32'h0);
    apb(CSP_OFF_STATUS, 1'b0, 32'h0, 32'h1);
    repeat (4) @(posedge clk_sys);
    report_and_stop();
  end
endmodule
bind csp_serial_port csp_serial_port_assertions u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .mclk_pin(mclk_pin), .sd_in_pin(sd_in_pin), .sck_out(sck_out), .fs_out(fs_out),
  .sd_out(sd_out), .irq(irq));
